// File: ddrct_core.sv
// Device-side DDR3 command timing: read window, auto precharge, recovery.
`timescale 1ns/1ps
`include "ddrct_params.svh"
module ddrct_core
   import ddrct_pkg::*;
(
   input  wire logic       i_clk,       // Core clock, 20 MHz.
   input  wire logic       i_rst,       // Asynchronous reset, active high.
   input  wire logic       i_ck,        // Link clock pin.
   input  wire logic       i_reset_n,   // Link reset pin, active low.
   input  wire logic       i_cke,       // Link clock enable pin.
   input  wire logic       i_cs_n,      // Chip select pin, active low.
   input  wire logic       i_ras_n,     // Row strobe pin, active low.
   input  wire logic       i_cas_n,     // Column strobe pin, active low.
   input  wire logic       i_we_n,      // Write enable pin, active low.
   input  wire logic       i_a10,       // Auto precharge address bit.
   input  wire logic       i_a12,       // Burst chop address bit, low = BC4.
   input  wire logic [2:0] i_ba,        // Bank address pins.
   input  wire logic       i_dll_off,   // DLL disabled mode.
   input  wire logic [3:0] i_cl,        // CAS latency in link cycles.
   input  wire logic [3:0] i_al,        // Additive latency in link cycles.
   input  wire logic [3:0] i_cwl,       // CAS write latency in link cycles.
   input  wire logic [1:0] i_bl_mode,   // Burst length mode.
   output logic            o_rd_win,    // Read strobe output window.
   output logic            o_strobe_oe, // Strobe output enable.
   output logic            o_int_pre,   // Internal precharge pulse.
   output logic      [2:0] o_pre_bank,  // Bank of internal precharge.
   output logic            o_rec_start, // Write recovery start pulse.
   output logic            o_rec_busy   // Write recovery in progress.
);

   logic [11:0]   pins_lvl;  // Synchronised pin levels.
   ddrct_state_t  q;         // Registered state.
   ddrct_state_t  d;         // Next state.
   logic [7:0]    ras_met;   // Row active time met per bank.
   logic          ck_en;     // Rising edge of the link clock.
   logic          cmd_ok;    // A command is sampled this cycle.
   logic          is_act;    // Activate command.
   logic          is_rd;     // Read command.
   logic          is_wr;     // Write command.
   logic [5:0]    rd_lat;    // Read window latency for this read.
   logic          bc4;       // Burst chopped to four for this command.

   // All link pins pass the three-stage synchroniser.
   ddrct_sync #(
      .W (12)
   ) u_sync (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .i_pin ({i_ck, i_reset_n, i_cke, i_cs_n, i_ras_n, i_cas_n,
               i_we_n, i_a10, i_a12, i_ba}),
      .o_lvl (pins_lvl)
   );

   // Command decode at each synced rising link clock edge.
   assign ck_en  = pins_lvl[11] & ~q.ck_prev;
   assign cmd_ok = ck_en & pins_lvl[10] & pins_lvl[9] & ~pins_lvl[8];
   assign is_act = cmd_ok & ~pins_lvl[7] & pins_lvl[6] & pins_lvl[5];
   assign is_rd  = cmd_ok & pins_lvl[7] & ~pins_lvl[6] & pins_lvl[5];
   assign is_wr  = cmd_ok & pins_lvl[7] & ~pins_lvl[6] & ~pins_lvl[5];
   assign bc4    = (i_bl_mode == DDRCT_BL_FIX4) ||
                   ((i_bl_mode == DDRCT_BL_OTF) && !pins_lvl[3]);

   assign rd_lat = 6'(i_cl) + 6'(i_al) -
                   (i_dll_off ? 6'(`DDRCT_DLL_OFF_ADV) : 6'h00);

   // Per-bank row active time check.
   genvar gb;
   generate
      for (gb = 0; gb < `DDRCT_NBANK; gb++)
      begin : g_bank
         assign ras_met[gb] = (q.ras_cnt[gb] >= 4'(`DDRCT_TRAS_CYC));
      end
   endgenerate

   // Next-state logic for the whole core.
   always_comb
   begin
      d           = q;
      d.ck_prev   = pins_lvl[11];
      d.rec_start = 1'b0;
      d.pre       = 1'b0;
      // Row timers count core cycles and saturate.
      for (int b = 0; b < `DDRCT_NBANK; b++)
      begin
         if (q.ras_cnt[b] != 4'hF)
         begin
            d.ras_cnt[b] = q.ras_cnt[b] + 4'h1;
         end
      end
      // Read window runs out one link cycle at a time.
      if (ck_en && q.rd_win)
      begin
         if (q.rd_beats == 3'h1)
         begin
            d.rd_win = 1'b0;
         end
         d.rd_beats = q.rd_beats - 3'h1;
      end
      if (ck_en && q.rd_arm)
      begin
         if (q.rd_cnt <= 6'h01)
         begin
            d.rd_arm   = 1'b0;
            d.rd_win   = 1'b1;
            d.rd_beats = q.rd_beats;
         end
         else
         begin
            d.rd_cnt = q.rd_cnt - 6'h01;
         end
      end
      // A new read arms the window counter.
      if (is_rd)
      begin
         d.rd_arm   = 1'b1;
         d.rd_cnt   = rd_lat;
         d.rd_beats = bc4 ? 3'(`DDRCT_RD_CK_BC4) : 3'(`DDRCT_RD_CK_BL8);
      end
      // Write recovery sequencer.
      case (q.wr_st)
         DDRCT_WR_IDLE:
         begin
            d.wr_st = DDRCT_WR_IDLE;
         end
         DDRCT_WR_LAT:
         begin
            if (ck_en)
            begin
               if (q.wr_cnt <= 6'h01)
               begin
                  d.wr_st     = DDRCT_WR_REC;
                  d.rec_start = 1'b1;
                  d.rec_ck    = 3'(`DDRCT_TWR_CK);
                  d.rec_cyc   = 4'(`DDRCT_TWR_CYC);
               end
               else
               begin
                  d.wr_cnt = q.wr_cnt - 6'h01;
               end
            end
         end
         DDRCT_WR_REC:
         begin
            if (ck_en && q.rec_ck != 3'h0)
            begin
               d.rec_ck = q.rec_ck - 3'h1;
            end
            if (q.rec_cyc != 4'h0)
            begin
               d.rec_cyc = q.rec_cyc - 4'h1;
            end
            if (q.rec_ck == 3'h0 && q.rec_cyc == 4'h0)
            begin
               d.wr_st = DDRCT_WR_IDLE;
            end
         end
         default:
         begin
            d.wr_st = DDRCT_WR_IDLE;
         end
      endcase
      // A write restarts the latency count to the recovery edge.
      if (is_wr)
      begin
         d.wr_st  = DDRCT_WR_LAT;
         d.wr_cnt = 6'(i_cwl) + 6'(i_al) +
                    ((i_bl_mode == DDRCT_BL_FIX4) ?
                     6'(`DDRCT_WR_TAIL_BC4) : 6'(`DDRCT_WR_TAIL_BL8));
      end
      for (int b = `DDRCT_NBANK - 1; b >= 0; b--)
      begin
         if (q.ap_pend[b] && ras_met[b] &&
             (!q.ap_wr[b] || q.wr_st == DDRCT_WR_IDLE))
         begin
            d.pre      = 1'b1;
            d.pre_bank = 3'(b);
         end
      end
      if (d.pre)
      begin
         d.ap_pend[d.pre_bank] = 1'b0;
      end
      // Auto precharge requests are taken after the precharge clear so a new one is not lost.
      if ((is_rd || is_wr) && pins_lvl[4])
      begin
         d.ap_pend[pins_lvl[2:0]] = 1'b1;
         d.ap_wr[pins_lvl[2:0]]   = is_wr;
      end
      // Activation restarts the bank's row timer.
      if (is_act)
      begin
         d.ras_cnt[pins_lvl[2:0]] = 4'h0;
         d.ap_pend[pins_lvl[2:0]] = 1'b0;
      end
      if (!pins_lvl[10])
      begin
         d         = '0;
         d.ck_prev = pins_lvl[11];
      end
   end

   // State register.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign o_rd_win    = q.rd_win;
   assign o_strobe_oe = q.rd_win;
   assign o_int_pre   = q.pre;
   assign o_pre_bank  = q.pre_bank;
   assign o_rec_start = q.rec_start;
   assign o_rec_busy  = (q.wr_st == DDRCT_WR_REC);

   // Helper registers for the assertions: link edge counts, captured latencies, row flags.
   logic [5:0] h_rd_n;   // Link edges since the read.
   logic [5:0] h_rd_lat; // Latency captured at the read.
   logic [5:0] h_wr_n;   // Link edges since the write.
   logic [5:0] h_wr_lat; // Expected count captured at the write.
   logic [3:0] h_bck;    // Link edges since the last recovery start.
   logic [7:0] h_ras_met; // Row active flags one core cycle back.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         h_rd_n   <= 6'h00;
         h_rd_lat <= 6'h00;
         h_wr_n   <= 6'h00;
         h_wr_lat <= 6'h00;
         h_bck    <= 4'h0;
         h_ras_met <= 8'h00;
      end
      else
      begin
         h_rd_n   <= is_rd ? 6'h00 : (ck_en ? h_rd_n + 6'h01 : h_rd_n);
         h_rd_lat <= is_rd ? rd_lat : h_rd_lat;
         h_wr_n   <= is_wr ? 6'h00 : (ck_en ? h_wr_n + 6'h01 : h_wr_n);
         h_wr_lat <= is_wr ? d.wr_cnt : h_wr_lat;
         h_bck    <= q.rec_start ? 4'h0 :
                     ((ck_en && h_bck != 4'hF) ? h_bck + 4'h1 : h_bck);
         h_ras_met <= ras_met;
      end
   end

   property p_rd_start;
      @(posedge i_clk) disable iff (i_rst)
      $rose(q.rd_win) |-> (h_rd_n == h_rd_lat || h_rd_lat == 6'h00);
   endproperty
   a_rd_start: assert property (p_rd_start)
      else $error("Read window opened at the wrong link cycle.");

   property p_pre_tras;
      @(posedge i_clk) disable iff (i_rst)
      q.pre |-> h_ras_met[q.pre_bank];
   endproperty
   a_pre_tras: assert property (p_pre_tras)
      else $error("Internal precharge before row active time.");

   property p_rec_start;
      @(posedge i_clk) disable iff (i_rst)
      q.rec_start |-> (h_wr_n == h_wr_lat || h_wr_lat == 6'h00);
   endproperty
   a_rec_start: assert property (p_rec_start)
      else $error("Write recovery started at the wrong link cycle.");

   property p_rec_len;
      @(posedge i_clk) disable iff (i_rst)
      ($fell(o_rec_busy) && pins_lvl[10] && !$past(is_wr))
         |-> $past(h_bck) >= 4'(`DDRCT_TWR_CK);
   endproperty
   a_rec_len: assert property (p_rec_len)
      else $error("Write recovery shorter than four link cycles.");

   property p_oe_reset;
      @(posedge i_clk) disable iff (i_rst)
      !pins_lvl[10] |=> !o_strobe_oe ##1 !o_int_pre;
   endproperty
   a_oe_reset: assert property (p_oe_reset)
      else $error("Outputs active while link reset is low.");

endmodule : ddrct_core

// File: ddrct_params.svh
// Timing and layout constants for the DDR3 command timing block.
`ifndef DDRCT_PARAMS_SVH
`define DDRCT_PARAMS_SVH

// Core clock period in picoseconds (20 MHz).
`define DDRCT_CLK_PS      50000
// Least row active time in picoseconds.
`define DDRCT_TRAS_PS     35000
// Least row active time in core cycles, rounded up.
`define DDRCT_TRAS_CYC    ((`DDRCT_TRAS_PS + `DDRCT_CLK_PS - 1) / `DDRCT_CLK_PS)
// Write recovery time floor in picoseconds.
`define DDRCT_TWR_PS      15000
// Write recovery floor in core cycles, rounded up.
`define DDRCT_TWR_CYC     ((`DDRCT_TWR_PS + `DDRCT_CLK_PS - 1) / `DDRCT_CLK_PS)
// Write recovery floor in link clock cycles.
`define DDRCT_TWR_CK      4
// Link cycles past write latency where recovery starts, BL8 or OTF BC4.
`define DDRCT_WR_TAIL_BL8 4
// Link cycles past write latency where recovery starts, fixed BC4.
`define DDRCT_WR_TAIL_BC4 2
// Link cycles of strobe window for BL8 and BC4.
`define DDRCT_RD_CK_BL8   4
`define DDRCT_RD_CK_BC4   2
// Read window advance with the DLL disabled.
`define DDRCT_DLL_OFF_ADV 1
// Number of banks.
`define DDRCT_NBANK       8

`endif

// File: ddrct_pkg.sv
// Types shared by the DDR3 command timing block.
package ddrct_pkg;

   // Burst length selection of the mode register.
   typedef enum logic [1:0]
   {
      DDRCT_BL_FIX8 = 2'h0,
      DDRCT_BL_OTF  = 2'h1,
      DDRCT_BL_FIX4 = 2'h2
   } ddrct_bl_t;

   // Write recovery sequencer states, Gray from idle through latency to recovery.
   typedef enum logic [1:0]
   {
      DDRCT_WR_IDLE = 2'h0,
      DDRCT_WR_LAT  = 2'h1,
      DDRCT_WR_REC  = 2'h3
   } ddrct_wr_st_t;

   // Complete state of the timing core.
   typedef struct packed
   {
      logic               ck_prev;   // Previous synced link clock level.
      logic [5:0]         rd_cnt;    // Link cycles left before read window.
      logic               rd_arm;    // A read is waiting for its window.
      logic [2:0]         rd_beats;  // Link cycles left in read window.
      logic               rd_win;    // Read strobe window active.
      ddrct_wr_st_t       wr_st;     // Write recovery sequencer state.
      logic [5:0]         wr_cnt;    // Link cycles left before recovery.
      logic [2:0]         rec_ck;    // Link cycles left of recovery.
      logic [3:0]         rec_cyc;   // Core cycles left of recovery.
      logic               rec_start; // One-cycle recovery start pulse.
      logic [7:0][3:0]    ras_cnt;   // Core cycles since activation.
      logic [7:0]         ap_pend;   // Auto precharge pending per bank.
      logic [7:0]         ap_wr;     // Pending precharge came from a write.
      logic               pre;       // Internal precharge pulse.
      logic [2:0]         pre_bank;  // Bank of the internal precharge.
   } ddrct_state_t;

endpackage : ddrct_pkg

// File: ddrct_sync.sv
// Three-stage synchroniser for the link pins.
`timescale 1ns/1ps
module ddrct_sync #(
   parameter int W = 12
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_pin,
   output logic      [W-1:0] o_lvl
);

   // Stage registers and the accepted level.
   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } ddrct_sync_st_t;

   ddrct_sync_st_t st_q;  // Registered state.
   ddrct_sync_st_t st_d;  // Next state.

   // A change is accepted only when stages two and three agree.
   always_comb
   begin
      st_d     = st_q;
      st_d.s1  = i_pin;
      st_d.s2  = st_q.s1;
      st_d.s3  = st_q.s2;
      for (int i = 0; i < W; i++)
      begin
         if (st_q.s2[i] == st_q.s3[i])
         begin
            st_d.lvl[i] = st_q.s3[i];
         end
      end
   end

   // State register.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign o_lvl = st_q.lvl;

endmodule : ddrct_sync

// File: ddrct_ctrl_model.sv
// Controller-side model that drives the link pins of the timing core.
`timescale 1ns/1ps
module ddrct_ctrl_model
(
   input  wire logic       i_clk,     // Core clock.
   input  wire logic       i_rst,     // Asynchronous reset, active high.
   output logic            o_ck,      // Link clock, free running.
   output logic            o_reset_n, // Link reset, active low.
   output logic            o_cke,     // Link clock enable.
   output logic            o_cs_n,    // Chip select, active low.
   output logic            o_ras_n,   // Row strobe, active low.
   output logic            o_cas_n,   // Column strobe, active low.
   output logic            o_we_n,    // Write enable, active low.
   output logic            o_a10,     // Auto precharge bit.
   output logic            o_a12,     // Burst chop bit, low selects BC4.
   output logic      [2:0] o_ba       // Bank address.
);
   logic [2:0] cnt_q; // Core cycles within one link period of eight.

   // The link clock runs free at one eighth of the core rate, 400 ns.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         cnt_q <= 3'h0;
      else
         cnt_q <= cnt_q + 3'h1;
   end
   assign o_ck = ~cnt_q[2];

   // reset held low
   // The pins start idle with the link reset asserted from time zero.
   initial
   begin
      o_reset_n = 1'b0;
      o_cke = 1'b0;
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hF;
      o_a10 = 1'b0;
      o_a12 = 1'b1;
      o_ba = 3'h0;
   end

   // enable follows reset
   // Clock enable follows reset, so power-down is never entered.
   task automatic set_reset(input logic lvl);
      @(posedge i_clk);
      o_reset_n <= lvl;
      o_cke <= lvl;
   endtask : set_reset

   // Drives one command from a falling link edge to the next, then idles.
   // The pins are steady four core cycles either side of the rising edge.
   task automatic send(input logic [3:0] cmd, input logic [2:0] ba,
                       input logic a10, input logic a12);
      @(posedge i_clk iff cnt_q == 3'h3);
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= cmd;
      o_ba <= ba;
      o_a10 <= a10;
      o_a12 <= a12;
      @(posedge i_clk iff cnt_q == 3'h3);
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} <= 4'hF;
   endtask : send

   // rows spread evenly
   // Row activation of one bank; scenarios rotate over several banks.
   task automatic act(input logic [2:0] ba);
      send(4'h3, ba, 1'b0, 1'b1);
   endtask : act

   // read while locked
   // Reads are only sent once latencies and DLL mode have settled.
   task automatic rd(input logic [2:0] ba, input logic ap, input logic bc);
      send(4'h5, ba, ap, bc);
   endtask : rd

   // Column write with optional auto precharge and burst chop.
   task automatic wr(input logic [2:0] ba, input logic ap, input logic bc);
      send(4'h4, ba, ap, bc);
   endtask : wr

   // refresh then precharge
   // A short run sits inside one refresh window; send always leaves an
   // idle link cycle, and the slow link clock needs a precharge-all.
   task automatic refresh();
      send(4'h1, 3'h0, 1'b0, 1'b1);
      send(4'h2, 3'h0, 1'b1, 1'b1);
   endtask : refresh
endmodule : ddrct_ctrl_model

// File: testbench.sv
// Self-checking bench for the DDR3 command timing core.
`timescale 1ns/1ps
module testbench;
   import ddrct_pkg::*;
   logic       clk;        // Core clock.
   logic       rst;        // Core reset.
   logic       dll_off;    // DLL disabled mode.
   logic [3:0] cl;         // CAS latency.
   logic [3:0] al;         // Additive latency.
   logic [3:0] cwl;        // Write latency.
   logic [1:0] bl_mode;    // Burst length mode.
   wire        ck, reset_n, cke, cs_n, ras_n, cas_n, we_n, a10, a12;
   wire  [2:0] ba;         // Bank pins.
   wire  [2:0] pre_bank;   // Bank of internal precharge.
   wire        rd_win, strobe_oe, int_pre, rec_start, rec_busy;
   int         num_errors = 0;
   int         tests_run = 0;
   int         link_cnt = 0; // Link rising edges seen.
   int         rec_at = 0;   // Link count at the last recovery start.
   int         pre_at = 0;   // Link count at the last internal precharge.
   int         pre_n = 0;    // Internal precharges seen.
   logic [2:0] pre_seen = 3'h0; // Bank of the last internal precharge.

   // The core clock toggles every half period of 25 ns.
   initial clk = 1'b0;
   always #25 clk = ~clk;

   ddrct_ctrl_model u_ctrl (.i_clk(clk), .i_rst(rst), .o_ck(ck),
      .o_reset_n(reset_n), .o_cke(cke), .o_cs_n(cs_n), .o_ras_n(ras_n),
      .o_cas_n(cas_n), .o_we_n(we_n), .o_a10(a10), .o_a12(a12), .o_ba(ba));

   ddrct_core u_dut (.i_clk(clk), .i_rst(rst), .i_ck(ck),
      .i_reset_n(reset_n), .i_cke(cke), .i_cs_n(cs_n), .i_ras_n(ras_n),
      .i_cas_n(cas_n), .i_we_n(we_n), .i_a10(a10), .i_a12(a12),
      .i_ba(ba), .i_dll_off(dll_off), .i_cl(cl), .i_al(al), .i_cwl(cwl),
      .i_bl_mode(bl_mode), .o_rd_win(rd_win), .o_strobe_oe(strobe_oe),
      .o_int_pre(int_pre), .o_pre_bank(pre_bank),
      .o_rec_start(rec_start), .o_rec_busy(rec_busy));

   // Counts link edges and notes when the one-cycle pulses appear.
   always @(posedge ck) link_cnt <= link_cnt + 1;
   always @(posedge clk)
   begin
      if (rec_start === 1'b1)
         rec_at <= link_cnt;
      if (int_pre === 1'b1)
      begin
         pre_at <= link_cnt;
         pre_n <= pre_n + 1;
         pre_seen <= pre_bank;
      end
   end

   // Compares one value and reports a difference at once.
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   // Moves to seven core cycles past the k-th next link rising edge.
   task automatic at_edge(input int k);
      repeat (k) @(posedge ck);
      repeat (7) @(posedge clk);
      #1;
   endtask : at_edge

   // settle after change
   // Mode inputs change only while idle, with a long settling gap.
   task automatic setup(input logic d, input logic [1:0] m,
                        input logic [3:0] c, input logic [3:0] a,
                        input logic [3:0] w);
      @(posedge clk);
      dll_off <= d;
      bl_mode <= m;
      cl <= c;
      al <= a;
      cwl <= w;
      repeat (16) @(posedge clk);
   endtask : setup

   // Read window start at CL+AL (one less with DLL off) and its length.
   task automatic test_read(input logic d, input logic [1:0] m,
                            input logic bc, input int len,
                            input logic [3:0] c, input logic [3:0] a);
      int n;
      n = int'(c) + int'(a) - int'(d);
      setup(d, m, c, a, 4'h5);
      u_ctrl.rd(3'h1, 1'b0, bc);
      at_edge(n - 1);
      check(8'({rd_win, strobe_oe}), 8'h0);
      at_edge(1);
      check(8'({rd_win, strobe_oe}), 8'h3);
      at_edge(len - 1);
      check(8'(rd_win), 8'h1);
      at_edge(1);
      check(8'({rd_win, strobe_oe}), 8'h0);
      $display("test read done");
   endtask : test_read

   // Recovery start, its four-cycle floor, and precharge held off after.
   task automatic test_write(input logic [1:0] m, input logic bc,
                             input int tail, input logic [3:0] w,
                             input logic [3:0] a);
      int base;
      int m_cnt;
      int n0;
      m_cnt = int'(w) + int'(a) + tail;
      setup(1'b1, m, 4'h5, a, w);
      u_ctrl.act(3'h5);
      n0 = pre_n;
      u_ctrl.wr(3'h5, 1'b1, bc);
      base = link_cnt;
      at_edge(m_cnt);
      check(8'(rec_at - base), 8'(m_cnt));
      check(8'(rec_busy), 8'h1);
      check(8'(pre_n - n0), 8'h0);
      at_edge(3);
      check(8'(rec_busy), 8'h1);
      at_edge(2);
      check(8'(rec_busy), 8'h0);
      check(8'(pre_n - n0), 8'h1);
      check(8'(pre_at - base), 8'(m_cnt + 4));
      check(8'(pre_seen), 8'h5);
      $display("test write done");
   endtask : test_write

   // Read auto precharge, activation cancelling a write one, link reset.
   task automatic test_precharge_reset();
      int n0;
      int base;
      setup(1'b0, DDRCT_BL_FIX8, 4'h5, 4'h1, 4'h5);
      u_ctrl.act(3'h2);
      u_ctrl.rd(3'h2, 1'b1, 1'b1);
      base = link_cnt;
      at_edge(1);
      check(8'(pre_at - base), 8'h0);
      check(8'(pre_seen), 8'h2);
      n0 = pre_n;
      u_ctrl.act(3'h6);
      u_ctrl.wr(3'h6, 1'b1, 1'b1);
      u_ctrl.act(3'h6);
      u_ctrl.refresh();
      at_edge(16);
      check(8'(pre_n - n0), 8'h0);
      u_ctrl.rd(3'h1, 1'b0, 1'b1);
      u_ctrl.set_reset(1'b0);
      at_edge(8);
      check(8'({rd_win, strobe_oe, rec_busy}), 8'h0);
      u_ctrl.set_reset(1'b1);
      $display("test precharge and reset done");
   endtask : test_precharge_reset

   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run();
      $display("checks %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : complete_run

   // Cuts a hang short well after the expected 1573 core cycles.
   initial
   begin
      #500000;
      num_errors++;
      complete_run();
   end

   // Reset, then every scenario in turn.
   initial
   begin
      rst = 1'b1;
      dll_off = 1'b0;
      cl = 4'h5;
      al = 4'h1;
      cwl = 4'h5;
      bl_mode = DDRCT_BL_FIX8;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      u_ctrl.set_reset(1'b1);
      repeat (8) @(posedge clk);
      test_read(1'b0, DDRCT_BL_FIX8, 1'b1, 4, 4'h5, 4'h1);
      test_read(1'b1, DDRCT_BL_FIX8, 1'b1, 4, 4'h6, 4'h0);
      test_read(1'b0, DDRCT_BL_FIX4, 1'b1, 2, 4'h7, 4'h2);
      test_read(1'b0, DDRCT_BL_OTF, 1'b0, 2, 4'h5, 4'h0);
      test_read(1'b1, DDRCT_BL_OTF, 1'b1, 4, 4'h5, 4'h3);
      test_write(DDRCT_BL_FIX8, 1'b1, 4, 4'h5, 4'h1);
      test_write(DDRCT_BL_OTF, 1'b1, 4, 4'h6, 4'h0);
      test_write(DDRCT_BL_OTF, 1'b0, 4, 4'h5, 4'h2);
      test_write(DDRCT_BL_FIX4, 1'b1, 2, 4'h7, 4'h0);
      test_precharge_reset();
      complete_run();
   end
endmodule : testbench
